// [include/pmd_pkg.sv]
package pmd_pkg;

	// Byte offsets of the disable registers on the bus
	localparam logic [11:0] MOD_A_OFFSET   = 12'h000;
	localparam logic [11:0] MOD_B_OFFSET   = 12'h004;
	localparam logic [11:0] DMA_OFFSET     = 12'h008;

	// Values after power-on reset
	localparam logic [15:0] MOD_A_RESET    = 16'h0000;
	localparam logic [15:0] MOD_B_RESET    = 16'h0000;
	localparam logic [15:0] DMA_RESET      = 16'h0000;

	// Implemented bits of each register
	localparam logic [15:0] MOD_A_MASK     = 16'hffff;
	localparam logic [15:0] MOTOR_MASK     = 16'h0600;
	localparam logic [15:0] MOD_B_MASK     = 16'h0003;
	localparam logic [15:0] DMA_MASK       = 16'h00f0;

	// Field positions in the first register
	localparam int TIMER_LO_BIT   = 11;
	localparam int ENCODER_BIT    = 10;
	localparam int PWM_BIT        = 9;
	localparam int CODEC_BIT      = 8;
	// Field positions in the second register
	localparam int I2C_TWO_BIT    = 1;
	localparam int ADC_TWO_BIT    = 0;
	// Field positions in the DMA register
	localparam int DMA_TWELVE_BIT = 7;
	localparam int DMA_EIGHT_BIT  = 6;
	localparam int DMA_FOUR_BIT   = 5;
	localparam int DMA_ZERO_BIT   = 4;

	// Bus responses
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;

	localparam int MOD_COUNT = 18;
	localparam int DMA_COUNT = 15;

	// Gating toward the peripherals: clock enables and held resets
	typedef struct packed {
		logic [MOD_COUNT-1:0] clk_en;
		logic [MOD_COUNT-1:0] rst;
		logic [DMA_COUNT-1:0] dma_clk_en;
		logic [DMA_COUNT-1:0] dma_rst;
	} periph_ctl_t;

endpackage

// [verilog/periph_disable_bank.sv]
`timescale 1ns/1ps

// Summary of operation
// - First register bits 15..11 switch off timers five..one when one.
// - First register bits 10, 9, 8 switch off encoder, PWM, codec port.
// - First register bits 7..4 switch off I2C one, UART two, UART one, SPI two.
// - First register bits 3..0 switch off SPI one, CAN two, CAN one, ADC one.
// - All disable bits are read/write and clear at power-on reset.
// - Encoder and PWM bits exist only on motor-control variants.
// - Second register bit 1 switches off I2C two, bit 0 ADC two.
// - DMA register bits 15..8 and 3..0 are unimplemented, read zero.
// - DMA register bit 7 switches off channels 12, 13, 14.
// - DMA register bit 6 switches off channels 8 to 11.
// - DMA register bit 5 switches off channels 4 to 7.
// - DMA register bit 4 switches off channels 0 to 3.
module periph_disable_bank #(
	parameter bit HAS_MOTOR_CTRL = 1'b1,
	parameter int ADDR_W         = 12
) (
	input  wire logic                 CLK_SYS_IN,
	input  wire logic                 RESETN_IN,
	input  wire logic [ADDR_W-1:0]    AXI_AWADDR_IN,
	input  wire logic                 AXI_AWVALID_IN,
	output logic                      AXI_AWREADY_OUT,
	input  wire logic [31:0]          AXI_WDATA_IN,
	input  wire logic [3:0]           AXI_WSTRB_IN,
	input  wire logic                 AXI_WVALID_IN,
	output logic                      AXI_WREADY_OUT,
	output logic [1:0]                AXI_BRESP_OUT,
	output logic                      AXI_BVALID_OUT,
	input  wire logic                 AXI_BREADY_IN,
	input  wire logic [ADDR_W-1:0]    AXI_ARADDR_IN,
	input  wire logic                 AXI_ARVALID_IN,
	output logic                      AXI_ARREADY_OUT,
	output logic [31:0]               AXI_RDATA_OUT,
	output logic [1:0]                AXI_RRESP_OUT,
	output logic                      AXI_RVALID_OUT,
	input  wire logic                 AXI_RREADY_IN,
	output pmd_pkg::periph_ctl_t      PERIPH_CTL_OUT
);
	import pmd_pkg::*;

	// Motor bits vanish on variants without motor-control hardware
	localparam logic [15:0] A_MASK = HAS_MOTOR_CTRL ? MOD_A_MASK : (MOD_A_MASK & ~MOTOR_MASK);

	// Refused at elaboration: the decoder reads address bits 11..2
	if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_check
		$error("ADDR_W must lie between 12 and 32");
	end

	typedef struct packed {
		logic              aw_rdy;
		logic              aw_full;
		logic [11:0]       aw_addr;
		logic              w_rdy;
		logic              w_full;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              b_valid;
		logic [1:0]        b_resp;
		logic              ar_rdy;
		logic              r_valid;
		logic [31:0]       r_data;
		logic [1:0]        r_resp;
		logic [15:0]       mod_a;
		logic [15:0]       mod_b;
		logic [15:0]       dma;
		periph_ctl_t       ctl;
	} state_t;

	state_t st;
	state_t next_st;

	// Word decode; low two address bits are ignored as AXI4-Lite allows
	function automatic logic [1:0] decode(input logic [11:0] addr);
		logic [1:0] sel;
		sel = 2'h3;
		case ({addr[11:2], 2'h0})
			MOD_A_OFFSET: sel = 2'h0;
			MOD_B_OFFSET: sel = 2'h1;
			DMA_OFFSET:   sel = 2'h2;
			default:      sel = 2'h3;
		endcase
		return sel;
	endfunction

	// Merge written byte lanes into a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] data,
			input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] val;
		val = old;
		if (strb[0]) begin
			val[7:0] = data[7:0];
		end
		if (strb[1]) begin
			val[15:8] = data[15:8];
		end
		return val & mask;
	endfunction

	// Next state: bus handshakes, register writes, gate outputs
	always_comb begin
		logic [1:0]  wsel;
		logic [1:0]  rsel;
		logic [15:0] rval;
		next_st = st;
		wsel = decode(st.aw_addr);
		rsel = decode(AXI_ARADDR_IN[11:0]);
		rval = 16'h0000;

		// Address and data are taken in either order
		if (st.aw_rdy && AXI_AWVALID_IN) begin
			next_st.aw_rdy = 1'b0;
			next_st.aw_full = 1'b1;
			next_st.aw_addr = AXI_AWADDR_IN[11:0];
		end
		if (st.w_rdy && AXI_WVALID_IN) begin
			next_st.w_rdy = 1'b0;
			next_st.w_full = 1'b1;
			next_st.w_data = AXI_WDATA_IN;
			next_st.w_strb = AXI_WSTRB_IN;
		end

		// Both halves present: commit the write and answer
		if (st.aw_full && st.w_full && !st.b_valid) begin
			next_st.aw_full = 1'b0;
			next_st.w_full = 1'b0;
			next_st.b_valid = 1'b1;
			next_st.b_resp = RESP_OKAY;
			case (wsel)
				2'h0: next_st.mod_a = merge(st.mod_a, st.w_data, st.w_strb, A_MASK);
				2'h1: next_st.mod_b = merge(st.mod_b, st.w_data, st.w_strb, MOD_B_MASK);
				2'h2: next_st.dma = merge(st.dma, st.w_data, st.w_strb, DMA_MASK);
				default: next_st.b_resp = RESP_SLVERR;
			endcase
		end
		if (st.b_valid && AXI_BREADY_IN) begin
			next_st.b_valid = 1'b0;
			next_st.aw_rdy = 1'b1;
			next_st.w_rdy = 1'b1;
		end

		// Reads answer one cycle after the address is taken
		case (rsel)
			2'h0: rval = st.mod_a;
			2'h1: rval = st.mod_b;
			2'h2: rval = st.dma;
			default: rval = 16'h0000;
		endcase
		if (st.ar_rdy && AXI_ARVALID_IN) begin
			next_st.ar_rdy = 1'b0;
			next_st.r_valid = 1'b1;
			next_st.r_data = {16'h0000, rval};
			next_st.r_resp = (rsel == 2'h3) ? RESP_SLVERR : RESP_OKAY;
		end
		if (st.r_valid && AXI_RREADY_IN) begin
			next_st.r_valid = 1'b0;
			next_st.ar_rdy = 1'b1;
		end

		// Gates follow the register value written on the same edge
		next_st.ctl.rst[15:0] = next_st.mod_a;
		next_st.ctl.rst[17] = next_st.mod_b[I2C_TWO_BIT];
		next_st.ctl.rst[16] = next_st.mod_b[ADC_TWO_BIT];
		next_st.ctl.dma_rst[14:12] = {3{next_st.dma[DMA_TWELVE_BIT]}};
		next_st.ctl.dma_rst[11:8] = {4{next_st.dma[DMA_EIGHT_BIT]}};
		next_st.ctl.dma_rst[7:4] = {4{next_st.dma[DMA_FOUR_BIT]}};
		next_st.ctl.dma_rst[3:0] = {4{next_st.dma[DMA_ZERO_BIT]}};
		// Clock stops exactly while reset is held, so no half-reset state
		next_st.ctl.clk_en = ~next_st.ctl.rst;
		next_st.ctl.dma_clk_en = ~next_st.ctl.dma_rst;
	end

	// State register; every peripheral starts enabled
	always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			st <= '0;
			st.aw_rdy <= 1'b1;
			st.w_rdy <= 1'b1;
			st.ar_rdy <= 1'b1;
			st.mod_a <= MOD_A_RESET;
			st.mod_b <= MOD_B_RESET;
			st.dma <= DMA_RESET;
			st.ctl.clk_en <= '1;
			st.ctl.dma_clk_en <= '1;
		end else begin
			st <= next_st;
		end
	end

	// Outputs come straight from the state flops
	assign AXI_AWREADY_OUT = st.aw_rdy;
	assign AXI_WREADY_OUT = st.w_rdy;
	assign AXI_BVALID_OUT = st.b_valid;
	assign AXI_BRESP_OUT = st.b_resp;
	assign AXI_ARREADY_OUT = st.ar_rdy;
	assign AXI_RVALID_OUT = st.r_valid;
	assign AXI_RDATA_OUT = st.r_data;
	assign AXI_RRESP_OUT = st.r_resp;
	assign PERIPH_CTL_OUT = st.ctl;

	// Checks on the gate mapping and the bus timing
	a_timer_gates: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		st.ctl.clk_en[15:TIMER_LO_BIT] == ~st.mod_a[15:TIMER_LO_BIT])
		else $error("timer gate does not follow its disable bit");

	a_low_gates: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		st.ctl.rst[CODEC_BIT:0] == st.mod_a[CODEC_BIT:0])
		else $error("low peripheral reset does not follow its bit");

	a_motor_absent: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		!HAS_MOTOR_CTRL |-> st.mod_a[ENCODER_BIT:PWM_BIT] == 2'h0)
		else $error("motor bits set on a variant without them");

	a_reset_clear: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		$rose(RESETN_IN) |-> (st.mod_a == 16'h0000 && st.mod_b == 16'h0000 && st.dma == 16'h0000 && (&st.ctl.clk_en)))
		else $error("disable bits not clear after reset");

	a_dma_unimpl: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(AXI_ARVALID_IN && st.ar_rdy && decode(AXI_ARADDR_IN[11:0]) == 2'h2)
			|=> (st.r_valid && st.r_data[15:8] == 8'h00 && st.r_data[3:0] == 4'h0))
		else $error("unimplemented DMA bits read nonzero");

	a_dma_reg_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(st.dma & ~DMA_MASK) == 16'h0000)
		else $error("unimplemented DMA bit holds a one");

	a_group_twelve: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		st.ctl.dma_clk_en[14:12] == {3{~st.dma[DMA_TWELVE_BIT]}})
		else $error("channels 12 to 14 do not follow their bit");

	a_group_eight: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		st.ctl.dma_rst[11:8] == {4{st.dma[DMA_EIGHT_BIT]}})
		else $error("channels 8 to 11 do not follow their bit");

	a_group_four: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		st.ctl.dma_rst[7:4] == {4{st.dma[DMA_FOUR_BIT]}})
		else $error("channels 4 to 7 do not follow their bit");

	a_group_zero: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		st.ctl.dma_clk_en[3:0] == {4{~st.dma[DMA_ZERO_BIT]}})
		else $error("channels 0 to 3 do not follow their bit");

	a_second_reg: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		{st.ctl.rst[17], st.ctl.rst[16]} == st.mod_b[1:0])
		else $error("I2C two or ADC two gate does not follow its bit");

	a_clock_stopped: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(st.ctl.rst == ~st.ctl.clk_en) && (st.ctl.dma_rst == ~st.ctl.dma_clk_en))
		else $error("clock runs while reset is held");

	a_write_lands: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(st.aw_full && st.w_full && !st.b_valid && decode(st.aw_addr) == 2'h0 && st.w_strb[0])
			|=> (st.mod_a[7:4] == $past(st.w_data[7:4]) && st.b_valid))
		else $error("write to first register not stored");

	a_read_answer: assert property (@(posedge CLK_SYS_IN) disable iff (!RESETN_IN)
		(AXI_ARVALID_IN && st.ar_rdy && decode(AXI_ARADDR_IN[11:0]) == 2'h0)
			|=> (st.r_valid && st.r_data[10:8] == $past(st.mod_a[10:8])))
		else $error("read of first register wrong or late");

endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	import pmd_pkg::*;
	logic                clk_sys = 1'b0;
	logic                rst_n   = 1'b0;
	logic [11:0]         awaddr  = 12'h000;
	logic [11:0]         araddr  = 12'h000;
	logic [31:0]         wdata   = 32'h0;
	logic [3:0]          wstrb   = 4'h0;
	logic                awvalid = 1'b0;
	logic                wvalid  = 1'b0;
	logic                bready  = 1'b0;
	logic                arvalid = 1'b0;
	logic                rready  = 1'b0;
	logic                awready, wready, bvalid, arready, rvalid;
	logic [1:0]          bresp, rresp;
	logic [31:0]         rdata;
	periph_ctl_t         ctl;
	periph_ctl_t         ctl_lean;
	logic [31:0]         rdata_lean;
	logic [1:0]          rresp_lean;
	logic [15:0]         regs [3] = '{default: 16'h0};
	logic [15:0]         masks [3] = '{MOD_A_MASK, MOD_B_MASK, DMA_MASK};
	logic [11:0]         addrs [4] = '{MOD_A_OFFSET, MOD_B_OFFSET, DMA_OFFSET, 12'h00c};
	logic [33:0]         rd_q [$];
	logic [1:0]          b_q [$];
	int                  errors = 0;
	int                  total_checks = 0;
	integer              seed = 32'hac635c0a;

	// Free-running system clock
	always #10 clk_sys = ~clk_sys;

	periph_disable_bank #(.HAS_MOTOR_CTRL(1'b1), .ADDR_W(12)) DUT (
		.CLK_SYS_IN(clk_sys), .RESETN_IN(rst_n),
		.AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(awready),
		.AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(wready),
		.AXI_BRESP_OUT(bresp), .AXI_BVALID_OUT(bvalid), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(arready),
		.AXI_RDATA_OUT(rdata), .AXI_RRESP_OUT(rresp), .AXI_RVALID_OUT(rvalid), .AXI_RREADY_IN(rready),
		.PERIPH_CTL_OUT(ctl)
	);

	// Variant without motor-control hardware, driven by the same bus
	periph_disable_bank #(.HAS_MOTOR_CTRL(1'b0), .ADDR_W(12)) DUT_LEAN (
		.CLK_SYS_IN(clk_sys), .RESETN_IN(rst_n),
		.AXI_AWADDR_IN(awaddr), .AXI_AWVALID_IN(awvalid), .AXI_AWREADY_OUT(),
		.AXI_WDATA_IN(wdata), .AXI_WSTRB_IN(wstrb), .AXI_WVALID_IN(wvalid), .AXI_WREADY_OUT(),
		.AXI_BRESP_OUT(), .AXI_BVALID_OUT(), .AXI_BREADY_IN(bready),
		.AXI_ARADDR_IN(araddr), .AXI_ARVALID_IN(arvalid), .AXI_ARREADY_OUT(),
		.AXI_RDATA_OUT(rdata_lean), .AXI_RRESP_OUT(rresp_lean), .AXI_RVALID_OUT(), .AXI_RREADY_IN(rready),
		.PERIPH_CTL_OUT(ctl_lean)
	);

	task automatic check(input string name, input logic [65:0] seen, input logic [65:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Register slot of an address, 3 for anything unmapped
	function automatic int idx(input logic [11:0] a);
		for (int k = 0; k < 3; k++) begin
			if (a[11:2] == addrs[k][11:2]) return k;
		end
		return 3;
	endfunction

	// Gate levels follow the shadow registers; DMA bits fan out to channel groups
	function automatic logic [65:0] gate_exp(input bit lean);
		periph_ctl_t e;
		e.rst = {regs[1][1:0], lean ? (regs[0] & ~MOTOR_MASK) : regs[0]};
		e.dma_rst = {{3{regs[2][7]}}, {4{regs[2][6]}}, {4{regs[2][5]}}, {4{regs[2][4]}}};
		e.clk_en = ~e.rst;
		e.dma_clk_en = ~e.dma_rst;
		return e;
	endfunction

	// Sampled mid-cycle so registered outputs have settled
	task automatic gate_chk();
		@(negedge clk_sys);
		check("gates", ctl, gate_exp(1'b0));
		check("lean gates", ctl_lean, gate_exp(1'b1));
	endtask

	// Handshakes are judged at the negedge before the edge that takes them
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		int i;
		bit aw, w, b;
		logic [15:0] m;
		k = idx(a);
		m = {{8{s[1]}}, {8{s[0]}}};
		if (k < 3) regs[k] = (regs[k] & ~m) | (d[15:0] & m & masks[k]);
		b_q.push_back(k < 3 ? RESP_OKAY : RESP_SLVERR);
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge clk_sys);
			aw = awvalid && awready;
			w = wvalid && wready;
			b = bvalid && bready;
			@(posedge clk_sys);
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
			if (b) break;
		end
		bready <= 1'b0;
		if (i == 50) begin
			check("write timeout", 66'(i), 66'(0));
			end_sim();
		end
	endtask

	task automatic rd(input logic [11:0] a);
		int k;
		int i;
		bit ar, r;
		k = idx(a);
		rd_q.push_back(k < 3 ? {RESP_OKAY, 16'h0, regs[k]} : {RESP_SLVERR, 32'h0});
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(negedge clk_sys);
			ar = arvalid && arready;
			r = rvalid && rready;
			@(posedge clk_sys);
			if (ar) arvalid <= 1'b0;
			if (r) break;
		end
		rready <= 1'b0;
		if (i == 50) begin
			check("read timeout", 66'(i), 66'(0));
			end_sim();
		end
	endtask

	// Response monitor: each answer is matched with the oldest note
	// An answer with no note pending counts as a mismatch
	always @(negedge clk_sys) begin
		logic [33:0] exp_rd;
		if (bvalid && bready) begin
			if (b_q.size() == 0) begin
				check("bresp note", 66'h0, 66'h1);
			end else begin
				check("bresp", 66'(bresp), 66'(b_q.pop_front()));
			end
		end
		if (rvalid && rready) begin
			if (rd_q.size() == 0) begin
				check("read note", 66'h0, 66'h1);
			end else begin
				exp_rd = rd_q.pop_front();
				check("read", 66'({rresp, rdata}), 66'(exp_rd));
				check("lean read", 66'({rresp_lean, rdata_lean}), 66'(exp_rd & ~{18'h0, MOTOR_MASK}));
			end
		end
	end

	// Main sequence: reset values, random traffic, all ones, reset in mid-run
	initial begin
		logic [11:0] a;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		gate_chk();
		for (int k = 0; k < 4; k++) rd(addrs[k]);
		for (int n = 0; n < 40; n++) begin
			a = addrs[$unsigned($random(seed)) % 4];
			wr(a, $random(seed), 4'($random(seed)));
			gate_chk();
			rd(a);
		end
		for (int k = 0; k < 4; k++) wr(addrs[k], 32'hffffffff, 4'hf);
		gate_chk();
		for (int k = 0; k < 4; k++) rd(addrs[k]);
		// A second reset must drop every disable at once, clock or not
		@(posedge clk_sys);
		rst_n <= 1'b0;
		regs = '{default: 16'h0};
		gate_chk();
		@(posedge clk_sys);
		rst_n <= 1'b1;
		for (int k = 0; k < 3; k++) rd(addrs[k]);
		gate_chk();
		repeat (3) @(posedge clk_sys);
		end_sim();
	end
endmodule
